// >>> core/tlfm_regs.v
/*
  Critical limits, shared hysteresis, diode fault flags and alert mask of a temperature monitor.
  Assumes the management bus slave presents byte reads and writes as one-cycle strobes on ref_clk,
  and that the measurement engine gives per-channel results, faults and out-of-limit levels.
*/
// Operation
// R1 - Four read/write external critical limits, reset zero.
// R2 - Read/write internal critical limit, reset zero.
// R3 - Shared hysteresis register, resets to 0x0A.
// R4 - Fault flags name channels behind summary fault.
// R5 - Reading fault flags returns then clears them.
// R6 - Fault bits 4..1 for channels 4..1.
// R7 - Masked channel never asserts the alert.
// R8 - Mask does not affect critical output.
// R9 - Mask bits 4..1 block channels, reset zero.
// R10 - Mask bit 0 blocks internal limit alerts.
// R11 - Critical holds until below limit minus hysteresis.
// R12 - Critical needs one to four consecutive exceedances.
// R13 - Limits compare in result format, next conversion.
// R14 - Host keeps destructive fault read value.
`timescale 1ns/1ps
`include "tlfm_consts.vh"
module tlfm_regs #(
  parameter CHANNELS = 5
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Measurement engine, index 0 is the internal channel
  input wire [CHANNELS-1:0] meas_valid,
  input wire [8*CHANNELS-1:0] meas_temp,
  input wire [CHANNELS-1:0] out_of_limit,
  input wire [CHANNELS-1:1] diode_fault,
  // Outputs
  output wire summary_fault,
  output reg alert_reg,
  output reg crit_pin_reg,
  output wire [CHANNELS-1:0] crit_state
);

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] limit_reg [0:CHANNELS-1];
  reg [7:0] hyst_reg;
  reg [4:0] mask_reg;
  reg [3:0] fault_reg;
  reg [3:0] fault_next;
  reg [2:0] consec_reg;
  wire [4:0] alert_src;
  integer i;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        limit_reg[i] <= `TLFM_RST_LIMIT; // R1 R2
      end
      hyst_reg <= `TLFM_RST_HYST; // R3
      mask_reg <= `TLFM_RST_MASK; // R9
      consec_reg <= `TLFM_RST_CONSEC;
    end else if (reg_wr) begin
      if (reg_addr == `TLFM_ADDR_EXT1_CRIT_LIMIT) begin
        limit_reg[1] <= reg_wdata; // R1
      end else if (reg_addr == `TLFM_ADDR_EXT2_CRIT_LIMIT) begin
        limit_reg[2] <= reg_wdata;
      end else if (reg_addr == `TLFM_ADDR_EXT3_CRIT_LIMIT) begin
        limit_reg[3] <= reg_wdata;
      end else if (reg_addr == `TLFM_ADDR_EXT4_CRIT_LIMIT) begin
        limit_reg[4] <= reg_wdata;
      end else if (reg_addr == `TLFM_ADDR_INTERNAL_CRIT_LIMIT) begin
        limit_reg[0] <= reg_wdata; // R2
      end else if (reg_addr == `TLFM_ADDR_CRIT_LIMIT_HYSTERESIS) begin
        hyst_reg <= reg_wdata; // R3
      end else if (reg_addr == `TLFM_ADDR_CHANNEL_ALERT_MASK) begin
        mask_reg <= reg_wdata[4:0]; // R9
      end else if (reg_addr == `TLFM_ADDR_CRIT_CONSEC) begin
        consec_reg <= reg_wdata[`TLFM_CONSEC_LSB+2:`TLFM_CONSEC_LSB];
      end
    end
  end

  // ****************************************
  // Fault flags
  // ****************************************
  // A fault reported in the same cycle as the clearing read stays set, so it is not lost.
  always @* begin
    fault_next = fault_reg;
    if (reg_rd && reg_addr == `TLFM_ADDR_EXT_DIODE_FAULT_FLAGS) begin
      fault_next = 4'h0; // R5
    end
    fault_next = fault_next | diode_fault[4:1]; // R6
  end

  always @(posedge ref_clk) begin
    if (!rstn) begin
      fault_reg <= `TLFM_RST_FAULT;
    end else begin
      fault_reg <= fault_next;
    end
  end

  assign summary_fault = |fault_reg; // R4

  // ****************************************
  // Read data
  // ****************************************
  always @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `TLFM_ADDR_EXT1_CRIT_LIMIT) begin
        reg_rdata <= limit_reg[1];
      end else if (reg_addr == `TLFM_ADDR_EXT2_CRIT_LIMIT) begin
        reg_rdata <= limit_reg[2];
      end else if (reg_addr == `TLFM_ADDR_EXT3_CRIT_LIMIT) begin
        reg_rdata <= limit_reg[3];
      end else if (reg_addr == `TLFM_ADDR_EXT4_CRIT_LIMIT) begin
        reg_rdata <= limit_reg[4];
      end else if (reg_addr == `TLFM_ADDR_INTERNAL_CRIT_LIMIT) begin
        reg_rdata <= limit_reg[0];
      end else if (reg_addr == `TLFM_ADDR_CRIT_LIMIT_HYSTERESIS) begin
        reg_rdata <= hyst_reg;
      end else if (reg_addr == `TLFM_ADDR_CHANNEL_ALERT_MASK) begin
        reg_rdata <= {3'h0, mask_reg};
      end else if (reg_addr == `TLFM_ADDR_CRIT_CONSEC) begin
        reg_rdata <= {1'b0, consec_reg, 4'h0};
      end else if (reg_addr == `TLFM_ADDR_EXT_DIODE_FAULT_FLAGS) begin
        reg_rdata <= {3'h0, fault_reg, 1'b0}; // R5
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ****************************************
  // Alert and critical outputs
  // ****************************************
  // The internal channel has no diode, so its mask only gates the limit event.
  assign alert_src[0] = out_of_limit[0] & ~mask_reg[`TLFM_MASK_INT_BIT]; // R10
  assign alert_src[4:1] = (out_of_limit[4:1] | fault_reg) & ~mask_reg[4:1]; // R7

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_crit
      tlfm_crit_channel u_crit (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .meas_valid(meas_valid[g]),
        .meas_temp(meas_temp[8*g+7:8*g]),
        .limit(limit_reg[g]),
        .hyst(hyst_reg),
        .consec_code(consec_reg),
        .crit_state_reg(crit_state[g])
      );
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (!rstn) begin
      alert_reg <= 1'b0;
      crit_pin_reg <= 1'b0;
    end else begin
      alert_reg <= |alert_src; // R7
      crit_pin_reg <= |crit_state; // R8
    end
  end

endmodule // tlfm_regs

// >>> core/tlfm_consts.vh
/*
  Constants of the thermal limit, fault and alert-mask register group.
  Assumes a byte-wide register port from the management bus slave.
*/
`ifndef TLFM_CONSTS_VH
`define TLFM_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define TLFM_ADDR_EXT1_CRIT_LIMIT 8'h19
`define TLFM_ADDR_EXT2_CRIT_LIMIT 8'h1A
`define TLFM_ADDR_EXT_DIODE_FAULT_FLAGS 8'h1B
`define TLFM_ADDR_CHANNEL_ALERT_MASK 8'h1F
`define TLFM_ADDR_INTERNAL_CRIT_LIMIT 8'h20
`define TLFM_ADDR_CRIT_LIMIT_HYSTERESIS 8'h21
`define TLFM_ADDR_CRIT_CONSEC 8'h22
`define TLFM_ADDR_EXT3_CRIT_LIMIT 8'h30
`define TLFM_ADDR_EXT4_CRIT_LIMIT 8'h38

// ****************************************
// Reset values
// ****************************************
`define TLFM_RST_LIMIT 8'h00
`define TLFM_RST_HYST 8'h0A
`define TLFM_RST_MASK 5'h00
`define TLFM_RST_FAULT 4'h0
`define TLFM_RST_CONSEC 3'h0

// ****************************************
// Field positions
// ****************************************
`define TLFM_FLT_LSB 1
`define TLFM_MASK_INT_BIT 0
`define TLFM_CONSEC_LSB 4

`endif

// >>> core/tlfm_crit_channel.v
/*
  One channel of critical-temperature detection with consecutive count and hysteresis.
  Assumes meas_valid pulses once per finished conversion on this channel.
*/
`timescale 1ns/1ps
module tlfm_crit_channel (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  // Measurement
  input wire meas_valid,
  input wire [7:0] meas_temp,
  // Configuration
  input wire [7:0] limit,
  input wire [7:0] hyst,
  input wire [2:0] consec_code,
  // Result
  output reg crit_state_reg
);

  reg [2:0] run_reg;
  reg [2:0] run_next;
  reg [2:0] need;
  wire over;
  wire [8:0] release_level;
  wire below_release;

  // The limit is sampled at each conversion, so writes apply from the next one.
  assign over = meas_temp > limit; // R13
  assign release_level = {1'b0, limit} - {1'b0, hyst};
  // A hysteresis above the limit gives a negative release level that can never be crossed.
  assign below_release = !release_level[8] && ({1'b0, meas_temp} < release_level); // R11

  always @* begin
    case (consec_code) // R12
      3'h1: need = 3'h2;
      3'h3: need = 3'h3;
      3'h7: need = 3'h4;
      default: need = 3'h1;
    endcase
  end

  always @* begin
    run_next = run_reg;
    if (meas_valid) begin
      if (!over) begin
        run_next = 3'h0;
      end else if (run_reg < need) begin
        run_next = run_reg + 3'h1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!rstn) begin
      run_reg <= 3'h0;
      crit_state_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      if (meas_valid) begin
        if (over && run_next >= need) begin
          crit_state_reg <= 1'b1; // R12
        end else if (below_release) begin
          crit_state_reg <= 1'b0; // R11
        end
      end
    end
  end

endmodule // tlfm_crit_channel

// >>> verif/tlfm_regs_monitor.sv
/* Assertions on the ports of tlfm_regs, bound into it.
   Assumes reads answer one cycle after the strobe. */
`timescale 1ns/1ps
module tlfm_regs_monitor #(parameter CHANNELS = 5) (
  // Clock, reset
  input wire ref_clk,
  input wire rstn,
  // Register port
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  // Engine
  input wire [CHANNELS-1:0] meas_valid,
  input wire [CHANNELS-1:0] out_of_limit,
  input wire [CHANNELS-1:1] diode_fault,
  // Outputs
  input wire summary_fault,
  input wire alert_reg,
  input wire crit_pin_reg,
  input wire [CHANNELS-1:0] crit_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_fb; reg_rd && reg_addr == 8'h1B |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[0]; endproperty
  a_fb: assert property (p_fb) else $error("fault byte");
  property p_fc; reg_rd && reg_addr == 8'h1B && diode_fault == '0 |=> !summary_fault; endproperty
  a_fc: assert property (p_fc) else $error("fault kept");
  property p_fs; diode_fault != '0 |=> summary_fault; endproperty
  a_fs: assert property (p_fs) else $error("fault lost");
  property p_mb; reg_rd && reg_addr == 8'h1F |=> reg_rdata[7:5] == 3'h0; endproperty
  a_mb: assert property (p_mb) else $error("mask byte");
  property p_aq; out_of_limit == '0 && diode_fault == '0 && !summary_fault |=> !alert_reg; endproperty
  a_aq: assert property (p_aq) else $error("alert");
  property p_cp; crit_pin_reg == $past(|crit_state); endproperty
  a_cp: assert property (p_cp) else $error("crit pin");
  property p_cv; ((crit_state ^ $past(crit_state)) & ~$past(meas_valid)) == '0; endproperty
  a_cv: assert property (p_cv) else $error("crit moved");
  property p_rh; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rh: assert property (p_rh) else $error("rdata");
endmodule // tlfm_regs_monitor
bind tlfm_regs tlfm_regs_monitor #(.CHANNELS(CHANNELS)) i_mon (.ref_clk, .rstn, .reg_rd, .reg_addr, .reg_rdata,
  .meas_valid, .out_of_limit, .diode_fault, .summary_fault, .alert_reg, .crit_pin_reg, .crit_state);

// >>> verif/tlfm_host.sv
/* Host model giving one-cycle byte strobes on the register port.
   Assumes the bench checks what comes back. */
`timescale 1ns/1ps
module tlfm_host (
  // Clock
  input wire ref_clk,
  // Register port
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  // Released address and data lines show their inverse and both strobes drop low, so a late sample cannot pass by luck.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge ref_clk);
    #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask
endmodule // tlfm_host

// >>> verif/tlfm_regs_bench.sv
/* Bench of tlfm_regs driven through a host model.
   Assumes one-cycle read latency. */
`timescale 1ns/1ps
module tlfm_regs_bench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic rd_d = 1'b0;
  logic [4:0] meas_valid = 5'h00;
  logic [39:0] meas_temp = 40'h0;
  logic [4:0] out_of_limit = 5'h00;
  logic [4:1] diode_fault = 4'h0;
  logic reg_wr, reg_rd, summary_fault, alert_reg, crit_pin_reg;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [4:0] crit_state;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h17708EE6;
  logic [7:0] ad[9] = '{8'h19, 8'h1A, 8'h1B, 8'h1F, 8'h20, 8'h21, 8'h30, 8'h38, 8'h23};
  logic [7:0] wm[9] = '{8'hFF, 8'hFF, 8'h00, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  tlfm_regs i_dut (.ref_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .meas_valid, .meas_temp,
    .out_of_limit, .diode_fault, .summary_fault, .alert_reg, .crit_pin_reg, .crit_state);
  tlfm_host i_host (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  initial forever #2.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] ex);
    checks_done++;
    if (seen !== ex) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    exp_q.push_back(ex);
    i_host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic meas(input logic [7:0] t);
    @(posedge ref_clk);
    #1;
    {meas_valid[0], meas_temp[7:0]} = {1'b1, t};
    @(posedge ref_clk);
    #1;
    {meas_valid[0], meas_temp[7:0]} = {1'b0, ~t};
  endtask
  // Read data is judged one edge after its strobe, oldest expectation first.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rd_d) chk("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    for (int i = 0; i < 9; i++) rd(ad[i], ad[i] == 8'h21 ? 8'h0A : 8'h00);
    for (int i = 0; i < 9; i++) begin
      seed = xs(seed);
      i_host.xfer(1'b1, ad[i], seed[7:0]);
      rd(ad[i], seed[7:0] & wm[i]);
    end
    diode_fault = seed[11:8] | 4'h1;
    @(posedge ref_clk);
    #1;
    diode_fault = 4'h0;
    chk("summary_fault", {7'h0, summary_fault}, 8'h01);
    rd(8'h1B, {3'h0, seed[11:8] | 4'h1, 1'b0});
    rd(8'h1B, 8'h00);
    i_host.xfer(1'b1, 8'h1F, 8'h1F);
    {out_of_limit, diode_fault} = 9'h1FF;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("alert_reg", {7'h0, alert_reg}, 8'h00);
    diode_fault = 4'h0;
    i_host.xfer(1'b1, 8'h1F, 8'h1E);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("alert_reg", {7'h0, alert_reg}, 8'h01);
    out_of_limit = 5'h00;
    i_host.xfer(1'b1, 8'h1F, 8'h1F);
    i_host.xfer(1'b1, 8'h21, 8'h0A);
    i_host.xfer(1'b1, 8'h20, 8'h50);
    // Count codes 000, 001, 011, 111 ask for one to four results over the limit.
    for (int k = 0; k < 4; k++) begin
      i_host.xfer(1'b1, 8'h22, ((8'h01 << k) - 8'h01) << 4);
      rd(8'h22, ((8'h01 << k) - 8'h01) << 4);
      repeat (k) meas(8'h51);
      chk("crit_state", {3'h0, crit_state}, 8'h00);
      meas(8'h51);
      chk("crit_state", {3'h0, crit_state}, 8'h01);
      meas(8'h46);
      chk("crit_pin_reg", {6'h0, crit_pin_reg, crit_state[0]}, 8'h03);
      meas(8'h45);
    end
    final_report();
  end
endmodule // tlfm_regs_bench
